// ---- core/tmc_core.sv ----
// Behaviour
// - edge mode: dir 0 up, 1 down
// - dir read-only in center or quadrature
// - mode 00 edge-aligned, direction from bit
// - mode 01 compare flags only counting down
// - mode 10 compare flags only counting up
// - mode 11 compare flags both directions
// - divider 1, 2, 4; 11 reserved
// - input filters sample on every CE_IN clock, not the divided one
// - all update sources raise request normally
// - restrict bit: only overflow raises request
// - update event from overflow, software, slave
// - suppress update, still reinit on ug/restart
// - single pulse clear: keep counting at update
// - single pulse: stop, clear enable at update
// - master source selects trigger output
// - slave mode 000 internal clock, 001-011 quadrature, 100 restart, 101 gated, 110 trigger, 111 external clock
// - sync enable delays master trigger output
//
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

module tmc_core #(
  parameter int CNT_W = 16
) (
  // clock and reset
  input  wire logic        CLK_IN,
  input  wire logic        NRST_IN,
  input  wire logic        CE_IN,
  // register port
  input  wire logic [7:0]  ADDR_IN,
  input  wire logic [31:0] WDATA_IN,
  input  wire logic        WR_IN,
  input  wire logic        RD_IN,
  output logic      [31:0] RDATA_OUT,
  // slave trigger and channel inputs
  input  wire logic        STI_IN,
  input  wire logic        TI0_IN,
  input  wire logic        TI1_IN,
  input  wire logic        CH0_CC_IN,
  input  wire logic [3:0]  CH_OREF_IN,
  // outputs
  output logic             MTO_OUT,
  output logic             DTS_EN_OUT,
  output logic             CMP_WIN_OUT,
  output logic             UPDATE_OUT,
  output logic             UPD_REQ_OUT,
  output logic             IRQ_OUT
);

  // ==========================================================
  // pin synchronisers
  logic [2:0] sti_s, ti0_s, ti1_s;
  logic       slave_trigger_input, ti0, ti1;
  always_ff @(posedge CLK_IN) begin
    if (!NRST_IN) begin
      sti_s <= 3'h0;
      ti0_s <= 3'h0;
      ti1_s <= 3'h0;
      slave_trigger_input   <= 1'b0;
      ti0   <= 1'b0;
      ti1   <= 1'b0;
    end else if (CE_IN) begin
      sti_s <= {sti_s[1:0], STI_IN};
      ti0_s <= {ti0_s[1:0], TI0_IN};
      ti1_s <= {ti1_s[1:0], TI1_IN};
      if (sti_s[1] == sti_s[2]) slave_trigger_input <= sti_s[2];
      if (ti0_s[1] == ti0_s[2]) ti0 <= ti0_s[2];
      if (ti1_s[1] == ti1_s[2]) ti1 <= ti1_s[2];
    end
  end

  logic sti_d, ti0_d, ti1_d;
  always_ff @(posedge CLK_IN) begin
    if (!NRST_IN) begin
      sti_d <= 1'b0;
      ti0_d <= 1'b0;
      ti1_d <= 1'b0;
    end else if (CE_IN) begin
      sti_d <= slave_trigger_input;
      ti0_d <= ti0;
      ti1_d <= ti1;
    end
  end
  wire logic sti_rise = slave_trigger_input & ~sti_d;
  wire logic ti0_edge = ti0 ^ ti0_d;
  wire logic ti1_edge = ti1 ^ ti1_d;

  // ==========================================================
  // registers
  tmc_pkg::tmc_cnt_cfg_s  cnt_cfg;
  tmc_pkg::tmc_mode_cfg_s mode_cfg;
  logic             run;
  logic [CNT_W-1:0] reload;
  logic [CNT_W-1:0] count;
  logic             hw_dir;
  logic [3:0]       irq_stat;
  logic [3:0]       irq_mask;

  wire logic wr_cnt  = WR_IN && ADDR_IN == tmc_pkg::ADDR_CNT_CFG;
  wire logic wr_mode = WR_IN && ADDR_IN == tmc_pkg::ADDR_MODE_CFG;
  wire logic wr_ctrl = WR_IN && ADDR_IN == tmc_pkg::ADDR_CTRL;
  wire logic sw_ug   = WR_IN && ADDR_IN == tmc_pkg::ADDR_EVENT
                       && WDATA_IN[tmc_pkg::UG_BIT];

  wire logic center = cnt_cfg.align != tmc_pkg::ALIGN_EDGE;
  wire logic quad   = mode_cfg.slave_sel == tmc_pkg::SLV_QUAD1
                   || mode_cfg.slave_sel == tmc_pkg::SLV_QUAD2
                   || mode_cfg.slave_sel == tmc_pkg::SLV_QUAD3;
  wire logic dir_ro = center | quad;

  always_ff @(posedge CLK_IN) begin
    if (!NRST_IN) begin
      cnt_cfg.dir          <= tmc_pkg::CNT_CFG_RST[tmc_pkg::DIR_BIT];
      cnt_cfg.align        <= tmc_pkg::tmc_align_e'(
          tmc_pkg::CNT_CFG_RST[tmc_pkg::ALIGN_LSB +: 2]);
      cnt_cfg.div          <= tmc_pkg::CNT_CFG_RST[tmc_pkg::DIV_LSB +: 2];
      cnt_cfg.irq_restrict <= tmc_pkg::CNT_CFG_RST[tmc_pkg::IRQ_RESTR_BIT];
      cnt_cfg.uev_suppress <= tmc_pkg::CNT_CFG_RST[tmc_pkg::UEV_SUPPR_BIT];
    end else if (CE_IN && wr_cnt) begin
      if (!dir_ro) cnt_cfg.dir <= WDATA_IN[tmc_pkg::DIR_BIT];
      cnt_cfg.align <= tmc_pkg::tmc_align_e'(
                         WDATA_IN[tmc_pkg::ALIGN_LSB +: 2]);
      cnt_cfg.div <= WDATA_IN[tmc_pkg::DIV_LSB +: 2];
      cnt_cfg.irq_restrict <= WDATA_IN[tmc_pkg::IRQ_RESTR_BIT];
      cnt_cfg.uev_suppress <= WDATA_IN[tmc_pkg::UEV_SUPPR_BIT];
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (!NRST_IN) begin
      mode_cfg.single_pulse <= tmc_pkg::MODE_CFG_RST[tmc_pkg::SPM_BIT];
      mode_cfg.master_src   <= tmc_pkg::MODE_CFG_RST[tmc_pkg::MSRC_LSB +: 3];
      mode_cfg.slave_sel    <= tmc_pkg::tmc_slave_e'(
          tmc_pkg::MODE_CFG_RST[tmc_pkg::SLAVE_LSB +: 3]);
      mode_cfg.sync_en      <= tmc_pkg::MODE_CFG_RST[tmc_pkg::SYNC_BIT];
    end else if (CE_IN && wr_mode) begin
      mode_cfg.single_pulse <= WDATA_IN[tmc_pkg::SPM_BIT];
      mode_cfg.master_src   <= WDATA_IN[tmc_pkg::MSRC_LSB +: 3];
      mode_cfg.slave_sel    <= tmc_pkg::tmc_slave_e'(
                                 WDATA_IN[tmc_pkg::SLAVE_LSB +: 3]);
      mode_cfg.sync_en      <= WDATA_IN[tmc_pkg::SYNC_BIT];
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (!NRST_IN) begin
      reload <= CNT_W'(tmc_pkg::RELOAD_RST);
    end else if (CE_IN && WR_IN && ADDR_IN == tmc_pkg::ADDR_RELOAD) begin
      reload <= WDATA_IN[CNT_W-1:0];
    end
  end

  // ==========================================================
  // dead-time sample clock enable; the input filters run on CE_IN
  logic [1:0] div_cnt;
  logic       dts_tick;
  always_comb begin
    case (cnt_cfg.div)
      2'b00:   dts_tick = 1'b1;
      2'b01:   dts_tick = div_cnt[0];
      2'b10:   dts_tick = &div_cnt;
      default: dts_tick = 1'b1;
    endcase
  end
  always_ff @(posedge CLK_IN) begin
    if (!NRST_IN) begin
      div_cnt    <= 2'h0;
      DTS_EN_OUT <= 1'b0;
    end else if (CE_IN) begin
      div_cnt    <= div_cnt + 2'h1;
      DTS_EN_OUT <= dts_tick;
    end
  end

  // ==========================================================
  // count clocking from slave mode
  logic cnt_tick;
  logic quad_up;
  always_comb begin
    quad_up = 1'b0;
    case (mode_cfg.slave_sel)
      tmc_pkg::SLV_OFF:    cnt_tick = run;
      tmc_pkg::SLV_QUAD1: begin
        cnt_tick = run & ti0_edge;
        quad_up  = ti0 ^ ti1;
      end
      tmc_pkg::SLV_QUAD2: begin
        cnt_tick = run & ti1_edge;
        quad_up  = ~(ti0 ^ ti1);
      end
      tmc_pkg::SLV_QUAD3: begin
        cnt_tick = run & (ti0_edge | ti1_edge);
        quad_up  = ti0_edge ? (ti0 ^ ti1) : ~(ti0 ^ ti1);
      end
      tmc_pkg::SLV_PAUSE:  cnt_tick = run & slave_trigger_input;
      tmc_pkg::SLV_EXTCLK: cnt_tick = run & sti_rise;
      default:             cnt_tick = run;
    endcase
  end
  wire logic hw_restart = mode_cfg.slave_sel == tmc_pkg::SLV_RESTART
                          && sti_rise;
  wire logic trg_start  = mode_cfg.slave_sel == tmc_pkg::SLV_TRIGGER
                          && sti_rise;

  // ==========================================================
  // counter
  wire logic up = center ? ~hw_dir : (quad ? quad_up : ~cnt_cfg.dir);
  wire logic at_top = count == reload;
  wire logic at_bot = count == '0;
  wire logic ovf    = cnt_tick && (up ? at_top : at_bot);
  // reload happens even while the update event is suppressed
  wire logic reinit = sw_ug | hw_restart;

  always_ff @(posedge CLK_IN) begin
    if (!NRST_IN) begin
      count  <= '0;
      hw_dir <= 1'b0;
    end else if (CE_IN) begin
      if (reinit) begin
        count  <= up ? '0 : reload;
        hw_dir <= cnt_cfg.dir;
      end else if (cnt_tick) begin
        if (center) begin
          if (!hw_dir && at_top) begin
            hw_dir <= 1'b1;
            count  <= count - 1'b1;
          end else if (hw_dir && at_bot) begin
            hw_dir <= 1'b0;
            count  <= count + 1'b1;
          end else begin
            count  <= hw_dir ? count - 1'b1 : count + 1'b1;
          end
        end else if (up) begin
          count <= at_top ? '0 : count + 1'b1;
        end else begin
          count <= at_bot ? reload : count - 1'b1;
        end
        if (!center && quad) hw_dir <= ~quad_up;
        else if (!center) hw_dir <= cnt_cfg.dir;
      end
    end
  end

  // ==========================================================
  // update event and request
  wire logic uev = !cnt_cfg.uev_suppress
                   && (ovf | sw_ug | hw_restart);
  wire logic ureq = uev && (!cnt_cfg.irq_restrict
                   || ovf);

  // run enable; single pulse stops it on the update event
  always_ff @(posedge CLK_IN) begin
    if (!NRST_IN) begin
      run <= 1'b0;
    end else if (CE_IN) begin
      if (mode_cfg.single_pulse && uev) run <= 1'b0;
      else if (wr_ctrl) run <= WDATA_IN[tmc_pkg::RUN_BIT];
      else if (trg_start) run <= 1'b1;
    end
  end

  // compare window by alignment mode
  logic cmp_win;
  always_comb begin
    case (cnt_cfg.align)
      tmc_pkg::ALIGN_CTR1: cmp_win = hw_dir;
      tmc_pkg::ALIGN_CTR2: cmp_win = ~hw_dir;
      tmc_pkg::ALIGN_CTR3: cmp_win = 1'b1;
      default:             cmp_win = 1'b1;
    endcase
  end

  // ==========================================================
  // master trigger output
  logic mto_src;
  always_comb begin
    case (mode_cfg.master_src)
      3'b000:  mto_src = sw_ug | hw_restart;
      3'b001:  mto_src = run;
      3'b010:  mto_src = uev;
      3'b011:  mto_src = CH0_CC_IN;
      3'b100:  mto_src = CH_OREF_IN[0];
      3'b101:  mto_src = CH_OREF_IN[1];
      3'b110:  mto_src = CH_OREF_IN[2];
      default: mto_src = CH_OREF_IN[3];
    endcase
  end
  // delay line lets a synchronised slave line up with the master
  logic [tmc_pkg::SYNC_DELAY_CYC-1:0] mto_dly;
  logic [tmc_pkg::SYNC_DELAY_CYC:0]   next_mto_dly;
  assign next_mto_dly = {mto_dly, mto_src};
  always_ff @(posedge CLK_IN) begin
    if (!NRST_IN) begin
      mto_dly <= '0;
      MTO_OUT <= 1'b0;
    end else if (CE_IN) begin
      mto_dly <= next_mto_dly[tmc_pkg::SYNC_DELAY_CYC-1:0];
      MTO_OUT <= mode_cfg.sync_en
                 ? mto_dly[tmc_pkg::SYNC_DELAY_CYC-1] : mto_src;
    end
  end

  // ==========================================================
  // event outputs and interrupts
  wire logic [3:0] irq_set = {trg_start, reinit, ovf, ureq};
  always_ff @(posedge CLK_IN) begin
    if (!NRST_IN) begin
      irq_stat <= tmc_pkg::IRQ_RST;
      irq_mask <= tmc_pkg::IRQ_RST;
    end else if (CE_IN) begin
      if (WR_IN && ADDR_IN == tmc_pkg::ADDR_IRQ_MASK)
        irq_mask <= WDATA_IN[3:0];
      // a new event wins over a clear in the same cycle
      if (WR_IN && ADDR_IN == tmc_pkg::ADDR_IRQ_STAT)
        irq_stat <= (irq_stat & ~WDATA_IN[3:0]) | irq_set;
      else
        irq_stat <= irq_stat | irq_set;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (!NRST_IN) begin
      UPDATE_OUT  <= 1'b0;
      UPD_REQ_OUT <= 1'b0;
      CMP_WIN_OUT <= 1'b0;
      IRQ_OUT     <= 1'b0;
    end else if (CE_IN) begin
      UPDATE_OUT  <= uev;
      UPD_REQ_OUT <= ureq;
      CMP_WIN_OUT <= cmp_win;
      IRQ_OUT     <= |((irq_stat | irq_set) & irq_mask);
    end
  end

  // ==========================================================
  // read port
  always_ff @(posedge CLK_IN) begin
    if (!NRST_IN) begin
      RDATA_OUT <= 32'h0000_0000;
    end else if (CE_IN) begin
      RDATA_OUT <= 32'h0000_0000;
      if (RD_IN) begin
        case (ADDR_IN)
          tmc_pkg::ADDR_CNT_CFG: begin
            // read-only direction shows what the counter really does
            RDATA_OUT[tmc_pkg::DIR_BIT] <= dir_ro ? hw_dir
                                           : cnt_cfg.dir;
            RDATA_OUT[tmc_pkg::ALIGN_LSB +: 2] <= cnt_cfg.align;
            RDATA_OUT[tmc_pkg::DIV_LSB +: 2]   <= cnt_cfg.div;
            RDATA_OUT[tmc_pkg::IRQ_RESTR_BIT]  <= cnt_cfg.irq_restrict;
            RDATA_OUT[tmc_pkg::UEV_SUPPR_BIT]  <= cnt_cfg.uev_suppress;
          end
          tmc_pkg::ADDR_MODE_CFG: begin
            RDATA_OUT[tmc_pkg::SPM_BIT]        <= mode_cfg.single_pulse;
            RDATA_OUT[tmc_pkg::MSRC_LSB +: 3]  <= mode_cfg.master_src;
            RDATA_OUT[tmc_pkg::SLAVE_LSB +: 3] <= mode_cfg.slave_sel;
            RDATA_OUT[tmc_pkg::SYNC_BIT]       <= mode_cfg.sync_en;
          end
          tmc_pkg::ADDR_CTRL:     RDATA_OUT[tmc_pkg::RUN_BIT] <= run;
          tmc_pkg::ADDR_RELOAD:   RDATA_OUT[CNT_W-1:0] <= reload;
          tmc_pkg::ADDR_COUNT:    RDATA_OUT[CNT_W-1:0] <= count;
          tmc_pkg::ADDR_IRQ_STAT: RDATA_OUT[3:0] <= irq_stat;
          tmc_pkg::ADDR_IRQ_MASK: RDATA_OUT[3:0] <= irq_mask;
          default:                RDATA_OUT <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule

`default_nettype wire

// ---- core/tmc_pkg.sv ----
package tmc_pkg;

  // ==========================================================
  // register map
  localparam logic [7:0] ADDR_CNT_CFG  = 8'h00;
  localparam logic [7:0] ADDR_MODE_CFG = 8'h04;
  localparam logic [7:0] ADDR_CTRL     = 8'h08;
  localparam logic [7:0] ADDR_EVENT    = 8'h0c;
  localparam logic [7:0] ADDR_RELOAD   = 8'h10;
  localparam logic [7:0] ADDR_COUNT    = 8'h14;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h18;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h1c;

  // ==========================================================
  // field positions
  localparam int DIR_BIT        = 24;
  localparam int ALIGN_LSB      = 16;
  localparam int DIV_LSB        = 8;
  localparam int IRQ_RESTR_BIT  = 1;
  localparam int UEV_SUPPR_BIT  = 0;
  localparam int SPM_BIT        = 24;
  localparam int MSRC_LSB       = 16;
  localparam int SLAVE_LSB      = 8;
  localparam int SYNC_BIT       = 0;
  localparam int RUN_BIT        = 0;
  localparam int UG_BIT         = 0;

  // ==========================================================
  // reset values
  localparam logic [31:0] CNT_CFG_RST  = 32'h0000_0000;
  localparam logic [31:0] MODE_CFG_RST = 32'h0000_0000;
  localparam logic [15:0] RELOAD_RST   = 16'hffff;
  localparam logic [3:0]  IRQ_RST      = 4'h0;

  // interrupt status bits
  localparam int IRQ_UPD  = 0;
  localparam int IRQ_OVF  = 1;
  localparam int IRQ_RLD  = 2;
  localparam int IRQ_TRG  = 3;

  // master trigger delay in timer clocks when sync enabled
  localparam int SYNC_DELAY_CYC = 1;

  typedef enum logic [1:0] {
    ALIGN_EDGE = 2'b00,
    ALIGN_CTR1 = 2'b01,
    ALIGN_CTR2 = 2'b10,
    ALIGN_CTR3 = 2'b11
  } tmc_align_e;

  typedef enum logic [2:0] {
    SLV_OFF     = 3'b000,
    SLV_QUAD1   = 3'b001,
    SLV_QUAD2   = 3'b010,
    SLV_QUAD3   = 3'b011,
    SLV_RESTART = 3'b100,
    SLV_PAUSE   = 3'b101,
    SLV_TRIGGER = 3'b110,
    SLV_EXTCLK  = 3'b111
  } tmc_slave_e;

  typedef struct packed {
    logic       dir;
    tmc_align_e align;
    logic [1:0] div;
    logic       irq_restrict;
    logic       uev_suppress;
  } tmc_cnt_cfg_s;

  typedef struct packed {
    logic       single_pulse;
    logic [2:0] master_src;
    tmc_slave_e slave_sel;
    logic       sync_en;
  } tmc_mode_cfg_s;

endpackage

// ---- verification/test_tmc_core.sv ----
`timescale 1ns/1ps
`default_nettype none

module test_tmc_core;
  // ==========================================================
  // design ports and bench state
  logic        CLK_IN;
  logic        NRST_IN, CE_IN, WR_IN, RD_IN;
  logic [7:0]  ADDR_IN;
  logic [31:0] WDATA_IN, RDATA_OUT, w;
  logic        STI_IN, TI0_IN, TI1_IN, CH0_CC_IN;
  logic [3:0]  CH_OREF_IN;
  logic        MTO_OUT, DTS_EN_OUT, CMP_WIN_OUT;
  logic        UPDATE_OUT, UPD_REQ_OUT, IRQ_OUT;
  logic        rd_pend = 1'b0;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  int          errors = 0;
  int          checks_done = 0;
  int          n_upd = 0, n_req = 0, n_dts = 0, b1, b2;

  tmc_core tmc_core_inst (
    .CLK_IN(CLK_IN), .NRST_IN(NRST_IN), .CE_IN(CE_IN), .ADDR_IN(ADDR_IN),
    .WDATA_IN(WDATA_IN), .WR_IN(WR_IN), .RD_IN(RD_IN),
    .RDATA_OUT(RDATA_OUT), .STI_IN(STI_IN), .TI0_IN(TI0_IN),
    .TI1_IN(TI1_IN), .CH0_CC_IN(CH0_CC_IN), .CH_OREF_IN(CH_OREF_IN),
    .MTO_OUT(MTO_OUT), .DTS_EN_OUT(DTS_EN_OUT), .CMP_WIN_OUT(CMP_WIN_OUT),
    .UPDATE_OUT(UPDATE_OUT), .UPD_REQ_OUT(UPD_REQ_OUT), .IRQ_OUT(IRQ_OUT));

  initial begin
    CLK_IN = 1'b0;
    forever #5 CLK_IN = ~CLK_IN;
  end

  // ==========================================================
  // tasks
  task automatic check(input string n, input logic [31:0] s, e);
    checks_done++;
    if (s !== e) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", n, e, s);
    end
  endtask

  task automatic close_out;
    $display("checks %0d, errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK_IN);
    ADDR_IN  <= a;
    WDATA_IN <= d;
    WR_IN    <= 1'b1;
    @(posedge CLK_IN);
    WR_IN    <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, m);
    exp_q.push_back(e & m);
    msk_q.push_back(m);
    @(posedge CLK_IN);
    ADDR_IN <= a;
    RD_IN   <= 1'b1;
    @(posedge CLK_IN);
    RD_IN   <= 1'b0;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge CLK_IN);
  endtask

  // ==========================================================
  // output monitor
  always @(posedge CLK_IN) rd_pend <= RD_IN && CE_IN && NRST_IN;

  always @(negedge CLK_IN) begin
    if (UPDATE_OUT === 1'b1) n_upd++;
    if (UPD_REQ_OUT === 1'b1) n_req++;
    if (DTS_EN_OUT === 1'b1) n_dts++;
    if (rd_pend === 1'b1) begin
      check("read data", RDATA_OUT & msk_q.pop_front(), exp_q.pop_front());
    end
  end

  initial begin
    #300us;
    errors++;
    close_out();
  end

  // ==========================================================
  // main sequence
  initial begin
    {NRST_IN, WR_IN, RD_IN, ADDR_IN, WDATA_IN} = '0;
    {STI_IN, TI0_IN, TI1_IN, CH0_CC_IN, CH_OREF_IN} = '0;
    CE_IN = 1'b1;
    void'($urandom(32));
    idle(2);
    NRST_IN <= 1'b1;
    rd(tmc_pkg::ADDR_CNT_CFG, tmc_pkg::CNT_CFG_RST, '1);
    rd(tmc_pkg::ADDR_MODE_CFG, tmc_pkg::MODE_CFG_RST, '1);
    rd(tmc_pkg::ADDR_RELOAD, {16'h0, tmc_pkg::RELOAD_RST}, 32'hffff);
    rd(8'h20, 32'h0, '1);
    for (int i = 0; i < 4; i++) begin
      w = $urandom() & 32'h0100_0303;
      wr(tmc_pkg::ADDR_CNT_CFG, w);
      rd(tmc_pkg::ADDR_CNT_CFG, w, 32'h0103_0303);
      w = $urandom() & 32'h0107_0401;
      wr(tmc_pkg::ADDR_MODE_CFG, w);
      rd(tmc_pkg::ADDR_MODE_CFG, w, 32'h0107_0701);
    end
    wr(tmc_pkg::ADDR_MODE_CFG, 32'h0);
    wr(tmc_pkg::ADDR_CNT_CFG, 32'h0100_0000);
    wr(tmc_pkg::ADDR_EVENT, 32'h1);
    rd(tmc_pkg::ADDR_COUNT, 32'hffff, 32'hffff);
    wr(tmc_pkg::ADDR_CNT_CFG, 32'h0001_0000);
    wr(tmc_pkg::ADDR_EVENT, 32'h1);
    wr(tmc_pkg::ADDR_CNT_CFG, 32'h0101_0000);
    rd(tmc_pkg::ADDR_CNT_CFG, 32'h0001_0000, 32'h0103_0000);
    for (int a = 1; a < 4; a++) begin
      wr(tmc_pkg::ADDR_CNT_CFG, a << 16);
      idle(3);
      check("compare window", CMP_WIN_OUT, a != 1);
    end
    wr(tmc_pkg::ADDR_CNT_CFG, 32'h0);
    wr(tmc_pkg::ADDR_MODE_CFG, 32'h100);
    wr(tmc_pkg::ADDR_CNT_CFG, 32'h0100_0000);
    rd(tmc_pkg::ADDR_CNT_CFG, 32'h0, 32'h0100_0000);
    wr(tmc_pkg::ADDR_MODE_CFG, 32'h0);
    for (int d = 0; d < 4; d++) begin
      wr(tmc_pkg::ADDR_CNT_CFG, d << 8);
      idle(8);
      b1 = n_dts;
      idle(8);
      check("sample pulses", n_dts - b1, d == 1 ? 4 : d == 2 ? 2 : 8);
    end
    // sticky reinit bit only unmasked
    wr(tmc_pkg::ADDR_IRQ_MASK, 32'h4);
    for (int i = 0; i < 4; i++) begin
      wr(tmc_pkg::ADDR_CNT_CFG, {7'h0, i[0], 22'h0, i[1], i[0]});
      b1 = n_upd;
      b2 = n_req;
      wr(tmc_pkg::ADDR_EVENT, 32'h1);
      idle(4);
      check("update events", n_upd - b1, !i[0]);
      check("update requests", n_req - b2, !i[0] && !i[1]);
      check("interrupt", IRQ_OUT, 1'b1);
      rd(tmc_pkg::ADDR_COUNT, i[0] ? 32'hffff : 32'h0, 32'hffff);
      rd(tmc_pkg::ADDR_IRQ_STAT, {29'h0, 1'b1, 1'b0, !i[0] && !i[1]}, 32'h5);
      wr(tmc_pkg::ADDR_IRQ_STAT, 32'hf);
      idle(2);
      check("interrupt", IRQ_OUT, 1'b0);
    end
    wr(tmc_pkg::ADDR_RELOAD, 32'h3);
    wr(tmc_pkg::ADDR_CNT_CFG, 32'h2);
    b2 = n_req;
    wr(tmc_pkg::ADDR_CTRL, 32'h1);
    idle(12);
    check("overflow requests", n_req - b2 >= 2, 1'b1);
    rd(tmc_pkg::ADDR_CTRL, 32'h1, 32'h1);
    wr(tmc_pkg::ADDR_MODE_CFG, 32'h0001_0000);
    idle(3);
    check("trigger output", MTO_OUT, 1'b1);
    wr(tmc_pkg::ADDR_MODE_CFG, 32'h0101_0000);
    idle(12);
    rd(tmc_pkg::ADDR_CTRL, 32'h0, 32'h1);
    rd(tmc_pkg::ADDR_COUNT, 32'h0, 32'hffff);
    check("trigger output", MTO_OUT, 1'b0);
    for (int k = 0; k < 8; k++) begin
      wr(tmc_pkg::ADDR_MODE_CFG, {13'h0, 1'b1, k[1:0], 15'h0, k[2]});
      repeat (20) begin
        @(posedge CLK_IN);
        CH_OREF_IN <= 4'($urandom());
      end
    end
    // slave pin: restart reloads the counter, trigger starts it
    wr(tmc_pkg::ADDR_CNT_CFG, 32'h0100_0000);
    wr(tmc_pkg::ADDR_MODE_CFG, 32'h0000_0400);
    b1 = n_upd;
    @(posedge CLK_IN);
    STI_IN <= 1'b1;
    idle(8);
    STI_IN <= 1'b0;
    idle(8);
    check("restart events", n_upd - b1, 32'h1);
    rd(tmc_pkg::ADDR_COUNT, 32'h3, 32'hffff);
    wr(tmc_pkg::ADDR_MODE_CFG, 32'h0000_0600);
    @(posedge CLK_IN);
    STI_IN <= 1'b1;
    idle(8);
    STI_IN <= 1'b0;
    idle(8);
    rd(tmc_pkg::ADDR_CTRL, 32'h1, 32'h1);
    idle(3);
    close_out();
  end
endmodule

`default_nettype wire

// ---- verification/tmc_core_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none

module tmc_core_assertions #(
  parameter int CNT_W = 16
) (
  input wire logic        CLK_IN,
  input wire logic        NRST_IN,
  input wire logic        CE_IN,
  input wire logic [7:0]  ADDR_IN,
  input wire logic [31:0] WDATA_IN,
  input wire logic        WR_IN,
  input wire logic        RD_IN,
  input wire logic [31:0] RDATA_OUT,
  input wire logic        STI_IN,
  input wire logic        TI0_IN,
  input wire logic        TI1_IN,
  input wire logic        CH0_CC_IN,
  input wire logic [3:0]  CH_OREF_IN,
  input wire logic        MTO_OUT,
  input wire logic        DTS_EN_OUT,
  input wire logic        CMP_WIN_OUT,
  input wire logic        UPDATE_OUT,
  input wire logic        UPD_REQ_OUT,
  input wire logic        IRQ_OUT
);
  // ==========================================================
  // shadow of the configuration fields
  logic [1:0] div;
  logic [1:0] align;
  logic       supp;
  logic       restr;
  logic       sync;
  logic [2:0] msrc;
  logic [3:0] quiet;
  logic       cfg_addr;

  assign cfg_addr = ADDR_IN == tmc_pkg::ADDR_CNT_CFG ||
                    ADDR_IN == tmc_pkg::ADDR_MODE_CFG;

  always_ff @(posedge CLK_IN) begin
    if (!NRST_IN) begin
      {div, align, supp, restr, sync, msrc} <= '0;
    end else if (CE_IN && WR_IN && ADDR_IN == tmc_pkg::ADDR_CNT_CFG) begin
      div   <= WDATA_IN[9:8];
      align <= WDATA_IN[17:16];
      restr <= WDATA_IN[1];
      supp  <= WDATA_IN[0];
    end else if (CE_IN && WR_IN && ADDR_IN == tmc_pkg::ADDR_MODE_CFG) begin
      msrc <= WDATA_IN[18:16];
      sync <= WDATA_IN[0];
    end
  end

  // cycles since the last configuration change, saturating
  always_ff @(posedge CLK_IN) begin
    if (!NRST_IN || !CE_IN || (WR_IN && cfg_addr)) begin
      quiet <= 4'h0;
    end else if (quiet != 4'hf) begin
      quiet <= quiet + 4'h1;
    end
  end

  // ==========================================================
  // properties
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!NRST_IN);

  sequence s_quarter;
    !DTS_EN_OUT [*3] ##1 DTS_EN_OUT;
  endsequence

  sequence s_ug;
    WR_IN && CE_IN && ADDR_IN == tmc_pkg::ADDR_EVENT && WDATA_IN[0];
  endsequence

  a_rdata_idle: assert property (!RD_IN && CE_IN |=> RDATA_OUT == 32'h0)
    else $error("read data not idle");
  a_dts_full: assert property (
    quiet > 4'h7 && div[1] == div[0] |-> DTS_EN_OUT)
    else $error("sample enable missing at full rate");
  a_dts_half: assert property (
    quiet > 4'h7 && div == 2'b01 && DTS_EN_OUT |=> !DTS_EN_OUT ##1 DTS_EN_OUT)
    else $error("sample enable not every second clock");
  a_dts_quarter: assert property (
    quiet > 4'h7 && div == 2'b10 && DTS_EN_OUT |=> s_quarter)
    else $error("sample enable not every fourth clock");
  a_uev_block: assert property (quiet > 4'h1 && supp |-> !UPDATE_OUT)
    else $error("update event while suppressed");
  a_req_uev: assert property (UPD_REQ_OUT |-> UPDATE_OUT)
    else $error("update request without update event");
  a_ug_request: assert property (
    s_ug ##0 (!supp && !restr) |=> ##[0:1] UPD_REQ_OUT)
    else $error("software update raised no request");
  a_mto_ref: assert property (
    quiet > 4'h3 && msrc[2] && !sync |->
      MTO_OUT == $past(CH_OREF_IN[msrc[1:0]]))
    else $error("trigger output not the compare reference");
  a_mto_sync: assert property (
    quiet > 4'h3 && msrc[2] && sync |->
      MTO_OUT == $past(CH_OREF_IN[msrc[1:0]], 2))
    else $error("trigger output not delayed by sync");
  a_cmp_both: assert property (quiet > 4'h1 && align == 2'b11 |-> CMP_WIN_OUT)
    else $error("compare window closed in mode three");
endmodule

bind tmc_core tmc_core_assertions #(.CNT_W(CNT_W)) tmc_core_assertions_inst (
  .CLK_IN(CLK_IN), .NRST_IN(NRST_IN), .CE_IN(CE_IN), .ADDR_IN(ADDR_IN),
  .WDATA_IN(WDATA_IN), .WR_IN(WR_IN), .RD_IN(RD_IN), .RDATA_OUT(RDATA_OUT),
  .STI_IN(STI_IN), .TI0_IN(TI0_IN), .TI1_IN(TI1_IN), .CH0_CC_IN(CH0_CC_IN),
  .CH_OREF_IN(CH_OREF_IN), .MTO_OUT(MTO_OUT), .DTS_EN_OUT(DTS_EN_OUT),
  .CMP_WIN_OUT(CMP_WIN_OUT), .UPDATE_OUT(UPDATE_OUT),
  .UPD_REQ_OUT(UPD_REQ_OUT), .IRQ_OUT(IRQ_OUT));

`default_nettype wire
